// [include/irq_regs_pkg.sv]
// Contract
// - timer enable word at F016, reset zero
// - bits 0..3 enable wide timers 0..3
// - bits 8..10 enable tick counters 0..2
// - acceptance clears global gate, enables kept
// - neighbour word bits 14,15 enable byte timers
// - request word at F018, reset zero
// - bit 0 is watchdog pending flag
// - watchdog request ignores global gate
// - low byte flags set on event always
// - bits 8..15 are pin event flags
// - pin flags set always, forwarded when enabled
// - software one write sets pending flag
// - acceptance clears the accepted flag
// - request-write interrupt waits one instruction; code holds only for a write of one to bit 0
// - pin enable byte bits 8..15 match flags
package irq_regs_pkg;
    localparam logic [15:0] TIMER_EN_ADDR = 16'hF016;
    localparam logic [15:0] PENDING_ADDR = 16'hF018;
    localparam logic [15:0] CONV_EN_ADDR = 16'hF014;
    localparam logic [15:0] PIN_EN_ADDR = 16'hF010;
    localparam logic [15:0] GATE_ADDR = 16'hF0F0;
    localparam logic [15:0] STAT_ADDR = 16'hF0F4;
    localparam logic [15:0] MASK_ADDR = 16'hF0F8;
    localparam logic [15:0] TIMER_EN_MASK = 16'h070F;
    localparam logic [15:0] CONV_EN_MASK = 16'hC000;
    localparam logic [15:0] PIN_EN_MASK = 16'hFF00;
    localparam logic [15:0] PENDING_MASK = 16'hFF01;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int WDOG_BIT = 0;
    localparam int PIN_LO = 8;
    localparam int BYTE_T6 = 14;
    localparam int BYTE_T7 = 15;
    localparam int SRC_WDOG = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_TMR = 2;
    localparam logic [1:0] SRC_W = 2'h3;
    localparam logic [2:0] STAT_W = 3'h7;
endpackage

// [design/irq_enable_request_regs.sv]
`timescale 1ns/100ps
module irq_enable_request_regs (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // source events, one-cycle pulses from same-clock logic
    input wire logic WDOG_EVENT,
    input wire logic [7:0] PIN_EVENT,
    input wire logic [3:0] WIDE_TIMER_EVENT,
    input wire logic [2:0] TICK_EVENT,
    input wire logic [1:0] BYTE_TIMER_EVENT,
    // cpu side
    input wire logic INSTR_DONE,
    input wire logic ACCEPT,
    input wire logic [3:0] ACCEPT_ID,
    input wire logic GATE_SET,
    output logic CPU_REQ,
    output logic GLOBAL_IRQ_GATE,
    output logic [15:0] TIMER_ENABLES,
    output logic [1:0] BYTE_TIMER_ENABLES,
    // block interrupt
    output logic IRQ
);
    import irq_regs_pkg::*;

    logic [15:0] timer_tick_enable_word;
    logic [15:0] converter_timer_enable_word;
    logic [15:0] pin_event_enable_byte;
    logic [15:0] pending_request_word_low;
    logic global_irq_gate;
    logic [2:0] stat;
    logic [2:0] mask;
    logic hold_req;
    logic wr;
    logic rd;
    logic [15:0] wmask;
    logic [15:0] wdat;
    logic [15:0] rword;
    logic hit;
    logic [15:0] accept_clr;
    logic [15:0] ev_set;
    logic maskable;
    logic next_req;

    ////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, byte lanes 0 and 1 carry 8/16-bit
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PENABLE && !PWRITE;
    assign wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
    assign wdat = PWDATA[15:0];
    assign PREADY = 1'b1;

    // read mux and mapped-address check
    always_comb begin
        hit = 1'b1;
        rword = WORD_RESET;
        case (PADDR)
            TIMER_EN_ADDR: rword = timer_tick_enable_word;
            CONV_EN_ADDR: rword = converter_timer_enable_word;
            PIN_EN_ADDR: rword = pin_event_enable_byte;
            PENDING_ADDR: rword = pending_request_word_low;
            GATE_ADDR: rword = {15'h0000, global_irq_gate};
            STAT_ADDR: rword = {13'h0000, stat};
            MASK_ADDR: rword = {13'h0000, mask};
            default: hit = 1'b0;
        endcase
    end

    // error only in the access phase of an unmapped address
    assign PSLVERR = PSEL && PENABLE && !hit;

    // read data registered in setup so it is stable in access
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= 32'h00000000;
        end else if (rd) begin
            PRDATA <= {16'h0000, rword};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // enable words: only documented bits exist, others read zero
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_tick_enable_word <= WORD_RESET;
            converter_timer_enable_word <= WORD_RESET;
            pin_event_enable_byte <= WORD_RESET;
        end else if (wr) begin
            // acceptance never touches these words
            if (PADDR == TIMER_EN_ADDR) begin
                timer_tick_enable_word <= (timer_tick_enable_word & ~wmask)
                    | (wdat & wmask & TIMER_EN_MASK);
            end
            if (PADDR == CONV_EN_ADDR) begin
                converter_timer_enable_word <=
                    (converter_timer_enable_word & ~wmask)
                    | (wdat & wmask & CONV_EN_MASK);
            end
            if (PADDR == PIN_EN_ADDR) begin
                pin_event_enable_byte <= (pin_event_enable_byte & ~wmask)
                    | (wdat & wmask & PIN_EN_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request flags: event or software one sets, acceptance clears
    always_comb begin
        accept_clr = 16'h0000;
        if (ACCEPT) begin
            if (ACCEPT_ID == 4'h0) begin
                accept_clr[WDOG_BIT] = 1'b1;
            end else if (ACCEPT_ID <= 4'h8) begin
                accept_clr[PIN_LO + int'(ACCEPT_ID) - 1] = 1'b1;
            end
        end
    end

    assign ev_set = {PIN_EVENT, 7'h00, WDOG_EVENT};

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pending_request_word_low <= WORD_RESET;
        end else begin
            // set wins over a same-cycle acceptance clear; software
            // zero writes also clear (plain r/w register)
            logic [15:0] nv;
            nv = pending_request_word_low & ~accept_clr;
            if (wr && PADDR == PENDING_ADDR) begin
                nv = (nv & ~wmask) | (wdat & wmask);
            end
            pending_request_word_low <= (nv | ev_set) & PENDING_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master gate: acceptance clears it, cpu or software sets it
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            global_irq_gate <= 1'b0;
        end else if (ACCEPT) begin
            global_irq_gate <= 1'b0;
        end else if (GATE_SET) begin
            global_irq_gate <= 1'b1;
        end else if (wr && PADDR == GATE_ADDR && PSTRB[0]) begin
            global_irq_gate <= PWDATA[0];
        end
    end

    // a watchdog request made by a write waits for one more instruction
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_req <= 1'b0;
        end else if (wr && PADDR == PENDING_ADDR && PSTRB[0]
                     && PWDATA[WDOG_BIT]) begin
            hold_req <= 1'b1;
        end else if (INSTR_DONE) begin
            hold_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // combined request towards the cpu
    assign maskable = |(pending_request_word_low & pin_event_enable_byte
                        & PIN_EN_MASK);
    assign next_req = !hold_req && (pending_request_word_low[WDOG_BIT]
                      || (global_irq_gate && maskable));
    assign CPU_REQ = next_req;
    assign GLOBAL_IRQ_GATE = global_irq_gate;
    assign TIMER_ENABLES = timer_tick_enable_word;
    assign BYTE_TIMER_ENABLES = {converter_timer_enable_word[BYTE_T7],
                                 converter_timer_enable_word[BYTE_T6]};

    ////////////////////////////////////////////////////////////////////
    // sticky event status, write one to clear, set wins
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat <= 3'h0;
            mask <= 3'h0;
        end else begin
            logic [2:0] clr;
            clr = (wr && PADDR == STAT_ADDR && PSTRB[0]) ? PWDATA[2:0]
                  : 3'h0;
            stat <= (stat & ~clr)
                | {|(WIDE_TIMER_EVENT) | (|TICK_EVENT)
                   | (|BYTE_TIMER_EVENT), |PIN_EVENT, WDOG_EVENT};
            if (wr && PADDR == MASK_ADDR && PSTRB[0]) begin
                mask <= PWDATA[2:0] & STAT_W;
            end
        end
    end

    assign IRQ = |(stat & mask);

    ////////////////////////////////////////////////////////////////////
    // checks
    wdog_nomask_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (pending_request_word_low[WDOG_BIT] && !hold_req) |-> CPU_REQ)
        else $error("watchdog request blocked");
    gate_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ACCEPT |=> !global_irq_gate)
        else $error("gate not cleared on accept");
    enable_kept_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (ACCEPT && !wr) |=> $stable(timer_tick_enable_word))
        else $error("enable changed on accept");
    wdog_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        WDOG_EVENT |=> pending_request_word_low[WDOG_BIT])
        else $error("watchdog flag not set");
    pin_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PIN_EVENT[0] |=> pending_request_word_low[PIN_LO])
        else $error("pin flag not set");
    accept_clr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (ACCEPT && ACCEPT_ID == 4'h1 && !PIN_EVENT[0] && !wr)
        |=> !pending_request_word_low[PIN_LO])
        else $error("accepted flag kept");
    masked_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (!global_irq_gate && !pending_request_word_low[WDOG_BIT])
        |-> !CPU_REQ)
        else $error("request without gate");
    sw_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == PENDING_ADDR && PSTRB[0] && PWDATA[0]
         && !INSTR_DONE) |=> !CPU_REQ)
        else $error("write request not held");
    sw_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == PENDING_ADDR && PSTRB[1] && PWDATA[15])
        |=> pending_request_word_low[15])
        else $error("software set lost");

    ////////////////////////////////////////////////////////////////////
    // register layout and forwarding checks, kept beside the logic

    // dead timer enable bits must never hold a one
    tmr_bits_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (timer_tick_enable_word & ~TIMER_EN_MASK) == WORD_RESET)
        else $error("dead timer enable bit set");

    // only the two byte timer bits live in the neighbour word
    conv_bits_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (converter_timer_enable_word & ~CONV_EN_MASK) == WORD_RESET)
        else $error("dead neighbour enable bit set");

    // pin enables occupy the high byte only
    pin_bits_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (pin_event_enable_byte & ~PIN_EN_MASK) == WORD_RESET)
        else $error("dead pin enable bit set");

    // reserved request bits stay zero even after a full-word write
    pend_bits_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (pending_request_word_low & ~PENDING_MASK) == WORD_RESET)
        else $error("reserved request bit set");

    // low lane write lands in the wide timer enables
    tmr_write_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == TIMER_EN_ADDR && PSTRB[0])
        |=> TIMER_ENABLES[3:0] == $past(PWDATA[3:0]))
        else $error("wide timer enable write lost");

    // high lane write lands in the tick counter enables
    tick_write_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == TIMER_EN_ADDR && PSTRB[1])
        |=> TIMER_ENABLES[10:8] == $past(PWDATA[10:8]))
        else $error("tick enable write lost");

    // byte timer enables follow a high lane write of the neighbour
    byte_write_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == CONV_EN_ADDR && PSTRB[1])
        |=> BYTE_TIMER_ENABLES == $past(PWDATA[15:14]))
        else $error("byte timer enable write lost");

    // pin enables follow a high lane write
    pin_write_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == PIN_EN_ADDR && PSTRB[1])
        |=> pin_event_enable_byte[15:8] == $past(PWDATA[15:8]))
        else $error("pin enable write lost");

    // an enabled pin request under an open gate must reach the cpu
    pin_fwd_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (global_irq_gate && pending_request_word_low[PIN_LO]
         && pin_event_enable_byte[PIN_LO] && !hold_req) |-> CPU_REQ)
        else $error("enabled pin request not forwarded");

    // pending pins without their enable never reach the cpu
    pin_block_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        ((pending_request_word_low & pin_event_enable_byte
          & PIN_EN_MASK) == WORD_RESET
         && !pending_request_word_low[WDOG_BIT]) |-> !CPU_REQ)
        else $error("disabled pin request forwarded");

    // accepting the watchdog drops its flag unless set again
    wdog_clr_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ACCEPT && ACCEPT_ID == 4'h0 && !WDOG_EVENT
         && !(wr && PADDR == PENDING_ADDR))
        |=> !pending_request_word_low[WDOG_BIT])
        else $error("accepted watchdog flag kept");

    // the top pin id maps onto the top flag
    pin7_clr_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ACCEPT && ACCEPT_ID == 4'h8 && !PIN_EVENT[7]
         && !(wr && PADDR == PENDING_ADDR))
        |=> !pending_request_word_low[15])
        else $error("accepted pin 7 flag kept");

    // top pin event sets the top flag
    pin7_set_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        PIN_EVENT[7] |=> pending_request_word_low[15])
        else $error("pin 7 flag not set");

    // a watchdog flag is sticky until accepted or written
    wdog_keep_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (pending_request_word_low[WDOG_BIT]
         && !(ACCEPT && ACCEPT_ID == 4'h0)
         && !(wr && PADDR == PENDING_ADDR))
        |=> pending_request_word_low[WDOG_BIT])
        else $error("watchdog flag lost");

    // software one on the watchdog bit makes it pending
    wdog_sw_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (wr && PADDR == PENDING_ADDR && PSTRB[0] && PWDATA[WDOG_BIT])
        |=> pending_request_word_low[WDOG_BIT])
        else $error("software watchdog set lost");

    // the hold lasts until an instruction completes
    hold_keep_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (hold_req && !INSTR_DONE) |=> hold_req)
        else $error("write hold released early");

    // one completed instruction frees a held request
    hold_free_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (hold_req && INSTR_DONE && !(wr && PADDR == PENDING_ADDR))
        |=> !hold_req)
        else $error("write hold stuck");

    // cpu gate set opens the gate unless an accept wins
    gate_set_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (GATE_SET && !ACCEPT) |=> GLOBAL_IRQ_GATE)
        else $error("gate set lost");

    // the timer enable register answers at once without error
    map_ok_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (PSEL && PENABLE && PADDR == TIMER_EN_ADDR) |-> PREADY && !PSLVERR)
        else $error("timer enable access refused");

    // request word read data captured at the setup edge
    rd_pend_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (PSEL && !PENABLE && !PWRITE && PADDR == PENDING_ADDR)
        |=> PRDATA == {16'h0000, $past(pending_request_word_low)})
        else $error("request word read wrong");

    // timer enable word read data captured at the setup edge
    rd_tmr_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (PSEL && !PENABLE && !PWRITE && PADDR == TIMER_EN_ADDR)
        |=> PRDATA == {16'h0000, $past(timer_tick_enable_word)})
        else $error("timer enable read wrong");

    // acceptance leaves the neighbour enables alone too
    conv_kept_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        (ACCEPT && !wr) |=> $stable(converter_timer_enable_word))
        else $error("neighbour enable changed on accept");
endmodule

// [sim/cpu_accept_model.sv]
`timescale 1ns/100ps
module cpu_accept_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench control
    input wire logic go,
    input wire logic [3:0] id,
    input wire logic [3:0] lag,
    input wire logic step,
    // block side
    input wire logic req,
    output logic accept,
    output logic [3:0] accept_id,
    output logic instr_done
);
    logic [3:0] cnt;
    logic fire;
    // one pulse per acceptance, so a stale request is never taken twice
    assign fire = go && req && !accept && cnt == lag;
    // lag lets the core be prompt or slow; the id toggles when idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            accept <= 1'b0;
            accept_id <= 4'hF;
            instr_done <= 1'b0;
        end else begin
            accept <= fire;
            accept_id <= fire ? id : ~accept_id;
            cnt <= (go && req && !accept && !fire) ? cnt + 4'h1 : 4'h0;
            instr_done <= step;
        end
    end
endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import irq_regs_pkg::*;
    typedef struct {
        logic [15:0] a;
        logic [15:0] d;
        logic [3:0] s;
        logic err;
        logic [15:0] e;
    } row_s;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, step = 1'b0;
    logic pready, pslverr, instr_done, accept, cpu_req, gate, irq;
    logic [15:0] paddr = 16'h0000, timer_en;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h0, id = 4'h0, lag = 4'h0, accept_id;
    logic [18:0] ev = 19'h0;
    logic [1:0] byte_en;
    logic [32:0] q;
    int n_mismatch = 0, samples_checked = 0;
    row_s rows [8] = '{
        '{TIMER_EN_ADDR, 16'hFFFF, 4'h3, 1'b0, 16'h070F},
        '{TIMER_EN_ADDR, 16'h0000, 4'h1, 1'b0, 16'h0700},
        '{CONV_EN_ADDR, 16'hFFFF, 4'h3, 1'b0, 16'hC000},
        '{PIN_EN_ADDR, 16'hFFFF, 4'h3, 1'b0, 16'hFF00},
        '{PENDING_ADDR, 16'hFFFF, 4'h2, 1'b0, 16'hFF00},
        '{PENDING_ADDR, 16'h0000, 4'h3, 1'b0, 16'h0000},
        '{MASK_ADDR, 16'h0007, 4'h3, 1'b0, 16'h0007},
        '{16'hF020, 16'hFFFF, 4'h3, 1'b1, 16'h0000}
    };
    irq_enable_request_regs u_irq_enable_request_regs (
        .SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .WDOG_EVENT(ev[17]), .PIN_EVENT(ev[16:9]), .WIDE_TIMER_EVENT(ev[8:5]),
        .TICK_EVENT(ev[4:2]), .BYTE_TIMER_EVENT(ev[1:0]), .GATE_SET(ev[18]),
        .INSTR_DONE(instr_done), .ACCEPT(accept), .ACCEPT_ID(accept_id),
        .CPU_REQ(cpu_req), .GLOBAL_IRQ_GATE(gate), .TIMER_ENABLES(timer_en),
        .BYTE_TIMER_ENABLES(byte_en), .IRQ(irq));
    cpu_accept_model u_cpu_accept_model (.clk(clk), .rst_b(rst_b), .go(go),
        .id(id), .lag(lag), .step(step), .req(cpu_req), .accept(accept),
        .accept_id(accept_id), .instr_done(instr_done));
    ////////////////////////////////////////////////////////////////////////
    // free-running system clock
    always #12.5 clk = ~clk;
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer; q holds {pslverr, prdata} of the access edge
    task automatic apb(input logic w, input logic [15:0] a,
            input logic [15:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_mismatch++;
        q = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // events last one cycle; checked after the taking edge settles
    task automatic pulse(input logic [18:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 19'h0;
        @(negedge clk);
    endtask
    task automatic take(input logic [3:0] i, input logic [3:0] l);
        int n;
        n = 0;
        @(posedge clk);
        id <= i;
        lag <= l;
        go <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (accept !== 1'b1 && n < 30);
        chk(33'(accept), 33'h1);
        go <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, far beyond the hundred-odd cycles the run needs
    initial begin
        #50000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(33'({gate, cpu_req, irq}), 33'h0);
        apb(0, PENDING_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h0);
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d, rows[i].s);
            chk(33'(q[32]), 33'(rows[i].err));
            apb(0, rows[i].a, 16'h0000, 4'h3);
            chk(q, {rows[i].err, 16'h0, rows[i].e});
        end
        @(negedge clk);
        chk(33'({timer_en, byte_en}), 33'h1C03);
        pulse(19'h10000);
        chk(33'(cpu_req), 33'h0);
        apb(0, PENDING_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h08000);
        pulse(19'h41000);
        chk(33'({gate, cpu_req}), 33'h3);
        take(4'h4, 4'h3);
        chk(33'({gate, cpu_req, timer_en}), 33'h0700);
        apb(0, PENDING_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h08000);
        pulse(19'h20000);
        chk(33'(cpu_req), 33'h1);
        take(4'h0, 4'h0);
        apb(0, PENDING_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h08000);
        chk(33'(irq), 33'h1);
        apb(1, STAT_ADDR, 16'h0003, 4'h3);
        apb(0, STAT_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h0);
        pulse(19'h00021);
        chk(33'(irq), 33'h1);
        apb(1, MASK_ADDR, 16'h0003, 4'h3);
        @(negedge clk);
        chk(33'(irq), 33'h0);
        apb(0, STAT_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h4);
        apb(1, PENDING_ADDR, 16'h0001, 4'h1);
        @(negedge clk);
        chk(33'(cpu_req), 33'h0);
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        repeat (2) @(negedge clk);
        chk(33'(cpu_req), 33'h1);
        take(4'h0, 4'h1);
        chk(33'(cpu_req), 33'h0);
        // software opens the gate; the old pin 7 flag is enabled
        apb(1, GATE_ADDR, 16'h0001, 4'h1);
        @(negedge clk);
        chk(33'({gate, cpu_req}), 33'h3);
        // reset in mid-run with a watchdog flag pending
        pulse(19'h20000);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(33'({gate, cpu_req, irq, timer_en}), 33'h0);
        apb(0, PENDING_ADDR, 16'h0000, 4'h3);
        chk(q, 33'h0);
        complete_run;
    end
endmodule
